/* File: design/pca_pkg.sv */
package pca_pkg;
	// ------------------------------------------------------------------
	// bus widths
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 16;
	localparam int MODE_W = 7;
	localparam int PRE_W  = 3;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_COUNTER_CONTROL_REG    = 8'hd8;
	localparam logic [7:0] ADDR_COUNTER_MODE_REG    = 8'hd9;
	localparam logic [7:0] ADDR_MODE0   = 8'hda;
	localparam logic [7:0] ADDR_CNT_LO  = 8'he9;
	localparam logic [7:0] ADDR_VLO0    = 8'hea;
	localparam logic [7:0] ADDR_CNT_HI  = 8'hf9;
	localparam logic [7:0] ADDR_VHI0    = 8'hfa;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int COUNTER_MODE_REG_IDLE = 7;
	localparam int COUNTER_MODE_REG_WATCHDOG_ENABLE = 6;
	localparam int COUNTER_MODE_REG_SRC1 = 2;
	localparam int COUNTER_MODE_REG_SRC0 = 1;
	localparam int COUNTER_MODE_REG_ECF  = 0;
	localparam int COUNTER_CONTROL_REG_CF   = 7;
	localparam int COUNTER_CONTROL_REG_CR   = 6;
	localparam int MODE_COMPARATOR_ENABLE = 6;
	localparam int MODE_RISING_EDGE_CAPTURE_ENABLE = 5;
	localparam int MODE_FALLING_EDGE_CAPTURE_ENABLE = 4;
	localparam int MODE_MAT  = 3;
	localparam int MODE_TOG  = 2;
	localparam int MODE_PWM  = 1;
	localparam int MODE_MODULE_IRQ_ENABLE = 0;

	// ------------------------------------------------------------------
	// count sources, prescale counts and reset values
	// ------------------------------------------------------------------
	localparam logic [1:0] SRC_DIV6 = 2'b00;
	localparam logic [1:0] SRC_DIV2 = 2'b01;
	localparam logic [1:0] SRC_T0   = 2'b10;
	localparam logic [1:0] SRC_EXT  = 2'b11;
	localparam logic [PRE_W-1:0] DIV6_CYC = 3'h6;
	localparam logic [PRE_W-1:0] DIV2_CYC = 3'h2;
	localparam logic [7:0]  REG_RST  = 8'h00;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'hffff;
	localparam logic [7:0]  LOW_MAX  = 8'hff;
	localparam int WDT_MOD = 4;
endpackage

/* File: design/pca_top.sv */
`timescale 1ns/1ns
// Operation
// - counter steps on clock/6, clock/2, timer 0 overflow or the external count pin.
// - one shared 16-bit counter is the time base of all five modules.
// - with halt_in_idle set the counter stops during processor idle.
// - watchdog_enable switches the watchdog, which lives on module 4 only.
// - counter runs only while counter_run is set.
// - overflow sets counter_overflow_flag; only software clears it; irq if enabled.
// - a match or capture sets module_event_flag; software clears it by writing.
// - module_irq_enable lets the module flag raise the interrupt.
// - pin_flip_on_hit inverts the module pin at each compare match.
// - compare_hit_flag_enable makes a compare match set the module flag.
// - falling and rising capture enables select the capturing edges, both means either.
// - the comparator works only while comparator_enable is set.
// - a capture copies both counter bytes into the value registers and sets the flag.
// - overflow and all module events merge into one interrupt request.
// - comparator and hit-flag enable together make a 16-bit software timer.
// - toggle, hit-flag and comparator enables together give high-speed toggle output.
// - pwm output low while counter low byte below value low, else high.
// - pwm reloads value low from value high when the low byte wraps.
// - pwm needs pwm-enable and comparator enable; all pwm share the counter.
// - watchdog match on module 4 raises an internal reset, not the reset pin.
// - unused counter array pins stay free for ordinary port use.
// - source code 00 div6, 01 div2, 10 timer 0, 11 pin at most clock/4.
module pca_top #(
	parameter int N_MOD = 5
) (
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	input  wire logic                        ce,
	input  wire logic [pca_pkg::ADDR_W-1:0]  addr,
	input  wire logic [pca_pkg::DATA_W-1:0]  wdata,
	input  wire logic                        wr_en,
	input  wire logic                        rd_en,
	output logic      [pca_pkg::DATA_W-1:0]  rdata,
	input  wire logic                        idle_mode,
	input  wire logic                        timer0_ovf,
	input  wire logic                        external_count_input,
	input  wire logic [N_MOD-1:0]            module_io_pin_in,
	output logic      [N_MOD-1:0]            module_io_pin_out,
	output logic      [N_MOD-1:0]            module_io_pin_oe,
	output logic                             irq,
	output logic                             wdt_reset
);
	import pca_pkg::*;

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	// the flag register holds five module bits and the watchdog sits on module 4
	if (N_MOD != 5) begin : g_bad_nmod
		$error("pca_top: N_MOD must be 5");
	end

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0]              cnt;
		logic [PRE_W-1:0]              pre;
		logic                          upd;
		logic                          halt_in_idle;
		logic                          watchdog_enable;
		logic [1:0]                    src;
		logic                          overflow_irq_enable;
		logic                          counter_run;
		logic                          counter_overflow_flag;
		logic [N_MOD-1:0]              module_event_flag;
		logic [N_MOD-1:0][MODE_W-1:0]  mode;
		logic [N_MOD-1:0][7:0]         vlo;
		logic [N_MOD-1:0][7:0]         vhi;
		logic [2:0]                    eci_s;
		logic [N_MOD-1:0][2:0]         pin_s;
		logic [N_MOD-1:0]              pin_out;
		logic [N_MOD-1:0]              pin_oe;
		logic                          irq;
		logic                          wdt_rst;
		logic [DATA_W-1:0]             rdata;
	} pca_state_type;

	pca_state_type st_r;
	pca_state_type st_nxt;

	logic             run;
	logic             tick;
	logic             ovf;
	logic             eci_fall;
	logic             cnt_wr;
	logic [N_MOD-1:0] hit;
	logic [N_MOD-1:0] cap;
	logic [N_MOD-1:0] pwm_mode;

	// returns {valid, index} when a lies within the module group at base
	function automatic logic [3:0] grp_sel(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		if (a >= base && d < 8'(N_MOD)) begin
			grp_sel = {1'b1, d[2:0]};
		end else begin
			grp_sel = 4'h0;
		end
	endfunction

	// ------------------------------------------------------------------
	// time base
	// ------------------------------------------------------------------
	assign run      = st_r.counter_run & ~(st_r.halt_in_idle & idle_mode);
	assign eci_fall = st_r.eci_s[2] & ~st_r.eci_s[1];
	assign cnt_wr   = wr_en & (addr == ADDR_CNT_LO || addr == ADDR_CNT_HI);
	assign ovf      = tick & (st_r.cnt == CNT_MAX);

	always_comb begin
		unique case (st_r.src)
			SRC_DIV6: tick = run & (st_r.pre == DIV6_CYC - 3'h1);
			SRC_DIV2: tick = run & (st_r.pre == DIV2_CYC - 3'h1);
			SRC_T0:   tick = run & timer0_ovf;
			SRC_EXT:  tick = run & eci_fall;
		endcase
	end

	// ------------------------------------------------------------------
	// per-module compare and capture detection
	// ------------------------------------------------------------------
	// upd marks a fresh counter value, so one count value matches only once
	for (genvar n = 0; n < N_MOD; n++) begin : g_mod
		logic rise;
		logic fall;
		assign rise = st_r.pin_s[n][1] & ~st_r.pin_s[n][2];
		assign fall = st_r.pin_s[n][2] & ~st_r.pin_s[n][1];
		assign pwm_mode[n] = st_r.mode[n][MODE_PWM] & st_r.mode[n][MODE_COMPARATOR_ENABLE];
		assign hit[n] = st_r.mode[n][MODE_COMPARATOR_ENABLE] & ~st_r.mode[n][MODE_PWM] & st_r.upd
			& (st_r.cnt == {st_r.vhi[n], st_r.vlo[n]});
		assign cap[n] = (st_r.mode[n][MODE_RISING_EDGE_CAPTURE_ENABLE] & rise) | (st_r.mode[n][MODE_FALLING_EDGE_CAPTURE_ENABLE] & fall);

		property p_hit_flag;
			@(posedge ref_clk) disable iff (!nrst)
			ce && hit[n] && st_r.mode[n][MODE_MAT] |=> st_r.module_event_flag[n];
		endproperty
		a_hit_flag: assert property (p_hit_flag) else $error("match did not set module flag");

		property p_toggle;
			@(posedge ref_clk) disable iff (!nrst)
			ce && hit[n] && st_r.mode[n][MODE_TOG] |=> st_r.pin_out[n] != $past(st_r.pin_out[n]);
		endproperty
		a_toggle: assert property (p_toggle) else $error("pin did not toggle on match");

		property p_capture;
			@(posedge ref_clk) disable iff (!nrst)
			ce && cap[n] |=> {st_r.vhi[n], st_r.vlo[n]} == $past(st_r.cnt) && st_r.module_event_flag[n];
		endproperty
		a_capture: assert property (p_capture) else $error("capture value or flag wrong");

		property p_pwm;
			@(posedge ref_clk) disable iff (!nrst)
			ce && pwm_mode[n] |=> st_r.pin_out[n] == ($past(st_r.cnt[7:0]) >= $past(st_r.vlo[n]));
		endproperty
		a_pwm: assert property (p_pwm) else $error("pwm level wrong");

		property p_pwm_reload;
			@(posedge ref_clk) disable iff (!nrst)
			ce && pwm_mode[n] && tick && st_r.cnt[7:0] == LOW_MAX && !wr_en
			|=> st_r.vlo[n] == $past(st_r.vhi[n]);
		endproperty
		a_pwm_reload: assert property (p_pwm_reload) else $error("pwm low value not reloaded");
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [3:0] sel;
		logic       any_irq;
		sel     = 4'h0;
		any_irq = 1'b0;
		st_nxt  = st_r;
		st_nxt.rdata   = REG_RST;
		st_nxt.wdt_rst = 1'b0;
		st_nxt.upd     = 1'b0;
		st_nxt.eci_s   = {st_r.eci_s[1:0], external_count_input};
		for (int n = 0; n < N_MOD; n++) begin
			st_nxt.pin_s[n] = {st_r.pin_s[n][1:0], module_io_pin_in[n]};
		end

		// prescaler only runs for the internal sources
		if (run && (st_r.src == SRC_DIV6 || st_r.src == SRC_DIV2)) begin
			if (tick) begin
				st_nxt.pre = 3'h0;
			end else begin
				st_nxt.pre = st_r.pre + 3'h1;
			end
		end
		if (tick) begin
			st_nxt.cnt = st_r.cnt + 16'h0001;
			st_nxt.upd = 1'b1;
		end

		// software writes; a counter write beats a tick in the same cycle
		if (wr_en) begin
			if (addr == ADDR_COUNTER_MODE_REG) begin
				st_nxt.halt_in_idle        = wdata[COUNTER_MODE_REG_IDLE];
				st_nxt.watchdog_enable     = wdata[COUNTER_MODE_REG_WATCHDOG_ENABLE];
				st_nxt.src                 = {wdata[COUNTER_MODE_REG_SRC1], wdata[COUNTER_MODE_REG_SRC0]};
				st_nxt.overflow_irq_enable = wdata[COUNTER_MODE_REG_ECF];
				// a leftover prescale count would stretch the first period of the new source
				st_nxt.pre                 = '0;
			end
			if (addr == ADDR_COUNTER_CONTROL_REG) begin
				st_nxt.counter_run           = wdata[COUNTER_CONTROL_REG_CR];
				st_nxt.counter_overflow_flag = wdata[COUNTER_CONTROL_REG_CF];
				st_nxt.module_event_flag     = wdata[N_MOD-1:0];
			end
			if (addr == ADDR_CNT_LO) begin
				st_nxt.cnt[7:0] = wdata;
				st_nxt.upd      = 1'b1;
			end
			if (addr == ADDR_CNT_HI) begin
				st_nxt.cnt[15:8] = wdata;
				st_nxt.upd       = 1'b1;
			end
			sel = grp_sel(addr, ADDR_MODE0);
			if (sel[3]) begin
				st_nxt.mode[sel[2:0]] = wdata[MODE_W-1:0];
			end
			sel = grp_sel(addr, ADDR_VLO0);
			if (sel[3]) begin
				st_nxt.vlo[sel[2:0]] = wdata;
			end
			sel = grp_sel(addr, ADDR_VHI0);
			if (sel[3]) begin
				st_nxt.vhi[sel[2:0]] = wdata;
			end
		end

		// register reads, data valid in the following cycle only
		if (rd_en) begin
			if (addr == ADDR_COUNTER_MODE_REG) begin
				st_nxt.rdata = {st_r.halt_in_idle, st_r.watchdog_enable, 3'h0, st_r.src,
					st_r.overflow_irq_enable};
			end
			if (addr == ADDR_COUNTER_CONTROL_REG) begin
				st_nxt.rdata = {st_r.counter_overflow_flag, st_r.counter_run, 1'b0,
					st_r.module_event_flag};
			end
			if (addr == ADDR_CNT_LO) begin
				st_nxt.rdata = st_r.cnt[7:0];
			end
			if (addr == ADDR_CNT_HI) begin
				st_nxt.rdata = st_r.cnt[15:8];
			end
			sel = grp_sel(addr, ADDR_MODE0);
			if (sel[3]) begin
				st_nxt.rdata = {1'b0, st_r.mode[sel[2:0]]};
			end
			sel = grp_sel(addr, ADDR_VLO0);
			if (sel[3]) begin
				st_nxt.rdata = st_r.vlo[sel[2:0]];
			end
			sel = grp_sel(addr, ADDR_VHI0);
			if (sel[3]) begin
				st_nxt.rdata = st_r.vhi[sel[2:0]];
			end
		end

		// hardware events come last so a set beats a clear in the same cycle
		if (ovf) begin
			st_nxt.counter_overflow_flag = 1'b1;
		end
		for (int n = 0; n < N_MOD; n++) begin
			if (pwm_mode[n]) begin
				st_nxt.pin_out[n] = st_r.cnt[7:0] >= st_r.vlo[n];
				if (tick && st_r.cnt[7:0] == LOW_MAX) begin
					st_nxt.vlo[n] = st_r.vhi[n];
				end
			end else if (hit[n] && st_r.mode[n][MODE_TOG]) begin
				st_nxt.pin_out[n] = ~st_r.pin_out[n];
			end
			if ((hit[n] && st_r.mode[n][MODE_MAT]) || cap[n]) begin
				st_nxt.module_event_flag[n] = 1'b1;
			end
			if (cap[n]) begin
				st_nxt.vlo[n] = st_r.cnt[7:0];
				st_nxt.vhi[n] = st_r.cnt[15:8];
			end
			// the pin is only driven when the module uses it as an output
			st_nxt.pin_oe[n] = st_nxt.mode[n][MODE_TOG] | (st_nxt.mode[n][MODE_PWM]
				& st_nxt.mode[n][MODE_COMPARATOR_ENABLE]);
			any_irq = any_irq | (st_nxt.module_event_flag[n] & st_nxt.mode[n][MODE_MODULE_IRQ_ENABLE]);
		end
		st_nxt.irq = any_irq | (st_nxt.counter_overflow_flag & st_nxt.overflow_irq_enable);

		// internal reset only; the external reset pin is never driven
		if (hit[WDT_MOD] && st_r.watchdog_enable) begin
			st_nxt.wdt_rst = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign rdata             = st_r.rdata;
	assign module_io_pin_out = st_r.pin_out;
	assign module_io_pin_oe  = st_r.pin_oe;
	assign irq               = st_r.irq;
	assign wdt_reset         = st_r.wdt_rst;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_ovf_flag;
		@(posedge ref_clk) disable iff (!nrst)
		ce && ovf |=> st_r.counter_overflow_flag;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

	property p_ovf_hold;
		@(posedge ref_clk) disable iff (!nrst)
		st_r.counter_overflow_flag && !(ce && wr_en && addr == ADDR_COUNTER_CONTROL_REG && !wdata[COUNTER_CONTROL_REG_CF])
		|=> st_r.counter_overflow_flag;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost without write");

	property p_run_stop;
		@(posedge ref_clk) disable iff (!nrst)
		ce && !st_r.counter_run && !cnt_wr |=> $stable(st_r.cnt);
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("counter moved while stopped");

	property p_idle;
		@(posedge ref_clk) disable iff (!nrst)
		ce && st_r.halt_in_idle && idle_mode && !cnt_wr |=> $stable(st_r.cnt);
	endproperty
	a_idle: assert property (p_idle) else $error("counter moved in idle");

	property p_div6;
		@(posedge ref_clk) disable iff (!nrst)
		ce && tick && st_r.src == SRC_DIV6 && st_r.counter_run && !idle_mode ##1 ce[*5]
		|-> !tick;
	endproperty
	a_div6: assert property (p_div6) else $error("div6 ticked early");

	property p_irq;
		@(posedge ref_clk) disable iff (!nrst)
		ce ##1 st_r.counter_overflow_flag && st_r.overflow_irq_enable |-> st_r.irq;
	endproperty
	a_irq: assert property (p_irq) else $error("overflow irq missing");

	property p_wdt;
		@(posedge ref_clk) disable iff (!nrst)
		ce && hit[WDT_MOD] && st_r.watchdog_enable |=> wdt_reset;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset missing");

	property p_wdt_off;
		@(posedge ref_clk) disable iff (!nrst)
		ce && !st_r.watchdog_enable |=> !wdt_reset;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("watchdog fired while disabled");

	property p_count;
		@(posedge ref_clk) disable iff (!nrst)
		ce && tick && !cnt_wr |=> st_r.cnt == $past(st_r.cnt) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("counter did not step on tick");
endmodule

/* File: bench/pca_pins_model.sv */
`timescale 1ns/1ns
module pca_pins_model (
	input  wire logic       ref_clk,
	input  wire logic [4:0] pin_out,
	input  wire logic [4:0] pin_oe,
	output logic            ext_count,
	output logic [4:0]      pin_level
);
	// ------------------------------------------------------------------
	// port pins with pull-ups
	// ------------------------------------------------------------------
	logic [4:0] drv_r;
	initial begin
		ext_count = 1'b1;
		drv_r = 5'h1f;
	end
	// a pin the block drives follows the block, any other pin stays with this side
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & drv_r);
	// each level is held 4 cycles so the pin never runs faster than clock/4
	task automatic ext_pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge ref_clk);
			ext_count <= 1'b0;
			repeat (4) @(posedge ref_clk);
			ext_count <= 1'b1;
		end
	endtask
	task automatic set_pin(input int i, input logic lvl);
		@(posedge ref_clk);
		drv_r[i] <= lvl;
	endtask
endmodule

/* File: bench/pca_top_test.sv */
`timescale 1ns/1ns
module pca_top_test;
	import pca_pkg::*;
	// ------------------------------------------------------------------
	// clock, reset and wiring
	// ------------------------------------------------------------------
	logic       ref_clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
	logic       idle_mode = 1'b0, timer0_ovf = 1'b0, irq, wdt_reset, external_count_input;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
	logic [4:0] module_io_pin_in, module_io_pin_out, module_io_pin_oe;
	int         n_mismatch = 0, checks_done = 0, wdt_cnt = 0;
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (wdt_reset === 1'b1) wdt_cnt <= wdt_cnt + 1;
	pca_top u_pca_top (.ref_clk, .nrst, .ce, .addr, .wdata, .wr_en, .rd_en, .rdata, .idle_mode,
		.timer0_ovf, .external_count_input, .module_io_pin_in, .module_io_pin_out,
		.module_io_pin_oe, .irq, .wdt_reset);
	pca_pins_model u_pca_pins_model (.ref_clk, .pin_out(module_io_pin_out),
		.pin_oe(module_io_pin_oe), .ext_count(external_count_input), .pin_level(module_io_pin_in));
	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task automatic get(input logic [7:0] a);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(negedge ref_clk);
		v = rdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		get(a);
		chk(what, {8'h00, v}, {8'h00, exp});
	endtask
	task automatic t0(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			timer0_ovf <= 1'b1;
			@(posedge ref_clk);
			timer0_ovf <= 1'b0;
		end
	endtask
	// outputs are registered, so look a little after the edge
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic setc(input logic [7:0] h, input logic [7:0] l);
		wr(ADDR_CNT_LO, l);
		wr(ADDR_CNT_HI, h);
	endtask
	task automatic clr;
		wr(ADDR_COUNTER_CONTROL_REG, 8'h00);
		for (int i = 0; i < 5; i++) wr(ADDR_MODE0 + 8'(i), 8'h00);
		wr(ADDR_COUNTER_MODE_REG, 8'h00);
	endtask
	task automatic sc_reset;
		rd(ADDR_COUNTER_CONTROL_REG, 8'h00, "counter_control_reg reset");
		rd(ADDR_VHI0 + 8'd4, 8'h00, "value high 4 reset");
		chk("oe and irq reset", {10'h000, module_io_pin_oe, irq}, 16'h0000);
		wr(ADDR_COUNTER_MODE_REG, 8'hff);
		rd(ADDR_COUNTER_MODE_REG, 8'hc7, "counter_mode_reg reserved bits");
		wr(8'h00, 8'h5a);
		rd(8'h00, 8'h00, "unmapped address");
	endtask
	task automatic sc_sources;
		clr;
		wr(ADDR_COUNTER_MODE_REG, 8'h04);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		t0(5);
		rd(ADDR_CNT_LO, 8'h05, "timer 0 count");
		wr(ADDR_COUNTER_CONTROL_REG, 8'h00);
		t0(3);
		rd(ADDR_CNT_LO, 8'h05, "stopped count");
		setc(8'h00, 8'h00);
		wr(ADDR_COUNTER_MODE_REG, 8'h06);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		u_pca_pins_model.ext_pulses(3);
		settle(6);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h00);
		rd(ADDR_CNT_LO, 8'h03, "external count");
		for (int s = 0; s < 2; s++) begin
			setc(8'h00, 8'h00);
			wr(ADDR_COUNTER_MODE_REG, s ? 8'h02 : 8'h00);
			wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
			repeat (60) @(posedge ref_clk);
			wr(ADDR_COUNTER_CONTROL_REG, 8'h00);
			get(ADDR_CNT_LO);
			chk("prescaled count", 16'(v >= (s ? 8'd29 : 8'd9) && v <= (s ? 8'd33 : 8'd12)), 16'h0001);
		end
	endtask
	task automatic sc_idle;
		clr;
		setc(8'h00, 8'h00);
		wr(ADDR_COUNTER_MODE_REG, 8'h84);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		idle_mode <= 1'b1;
		t0(2);
		rd(ADDR_CNT_LO, 8'h00, "halted in idle");
		wr(ADDR_COUNTER_MODE_REG, 8'h04);
		t0(2);
		rd(ADDR_CNT_LO, 8'h02, "running in idle");
		@(posedge ref_clk);
		idle_mode <= 1'b0;
	endtask
	task automatic sc_overflow;
		clr;
		setc(8'hff, 8'hff);
		wr(ADDR_COUNTER_MODE_REG, 8'h05);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		t0(1);
		rd(ADDR_CNT_HI, 8'h00, "wrapped high byte");
		chk("overflow irq", {15'h0000, irq}, 16'h0001);
		t0(1);
		rd(ADDR_COUNTER_CONTROL_REG, 8'hc0, "overflow flag sticky");
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		rd(ADDR_COUNTER_CONTROL_REG, 8'h40, "overflow flag cleared");
		chk("irq after clear", {15'h0000, irq}, 16'h0000);
	endtask
	task automatic sc_compare;
		clr;
		setc(8'h00, 8'h00);
		wr(ADDR_VLO0, 8'h03);
		wr(ADDR_VLO0 + 8'd1, 8'h03);
		wr(ADDR_MODE0, 8'h0c);
		wr(ADDR_MODE0 + 8'd1, 8'h4d);
		wr(ADDR_COUNTER_MODE_REG, 8'h04);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		t0(3);
		settle(2);
		rd(ADDR_COUNTER_CONTROL_REG, 8'h42, "match flags");
		chk("toggled pin", {11'h000, module_io_pin_out & 5'h03}, 16'h0002);
		chk("timer irq", {15'h0000, irq}, 16'h0001);
		wr(ADDR_MODE0 + 8'd1, 8'h4c);
		settle(2);
		chk("masked irq", {15'h0000, irq}, 16'h0000);
		wr(ADDR_CNT_LO, 8'h02);
		t0(1);
		settle(2);
		chk("toggled back", {15'h0000, module_io_pin_out[1]}, 16'h0000);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		rd(ADDR_COUNTER_CONTROL_REG, 8'h40, "module flag cleared");
	endtask
	task automatic sc_capture;
		clr;
		setc(8'h12, 8'h34);
		wr(ADDR_MODE0 + 8'd2, 8'h20);
		u_pca_pins_model.set_pin(2, 1'b0);
		settle(8);
		rd(ADDR_COUNTER_CONTROL_REG, 8'h00, "falling edge ignored");
		u_pca_pins_model.set_pin(2, 1'b1);
		settle(8);
		rd(ADDR_COUNTER_CONTROL_REG, 8'h04, "capture flag");
		rd(ADDR_VLO0 + 8'd2, 8'h34, "captured low");
		rd(ADDR_VHI0 + 8'd2, 8'h12, "captured high");
		wr(ADDR_CNT_HI, 8'h56);
		wr(ADDR_MODE0 + 8'd2, 8'h30);
		u_pca_pins_model.set_pin(2, 1'b0);
		settle(8);
		rd(ADDR_VHI0 + 8'd2, 8'h56, "either edge capture");
	endtask
	task automatic sc_pwm;
		clr;
		setc(8'h00, 8'h20);
		wr(ADDR_VLO0 + 8'd3, 8'h10);
		wr(ADDR_VHI0 + 8'd3, 8'h80);
		wr(ADDR_MODE0 + 8'd3, 8'h42);
		settle(2);
		chk("pwm high", {14'h0000, module_io_pin_oe[3], module_io_pin_out[3]}, 16'h0003);
		wr(ADDR_CNT_LO, 8'h0f);
		settle(2);
		chk("pwm low", {15'h0000, module_io_pin_out[3]}, 16'h0000);
		wr(ADDR_CNT_LO, 8'hff);
		wr(ADDR_COUNTER_MODE_REG, 8'h04);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		t0(1);
		rd(ADDR_VLO0 + 8'd3, 8'h80, "pwm reload");
		wr(ADDR_CNT_LO, 8'h80);
		settle(2);
		chk("pwm at threshold", {15'h0000, module_io_pin_out[3]}, 16'h0001);
		wr(ADDR_MODE0 + 8'd3, 8'h02);
		settle(2);
		chk("pwm without comparator", {15'h0000, module_io_pin_oe[3]}, 16'h0000);
	endtask
	task automatic sc_wdt;
		clr;
		setc(8'h00, 8'h00);
		wr(ADDR_VLO0 + 8'd4, 8'h02);
		wr(ADDR_MODE0 + 8'd4, 8'h40);
		wr(ADDR_COUNTER_MODE_REG, 8'h04);
		wr(ADDR_COUNTER_CONTROL_REG, 8'h40);
		t0(2);
		settle(3);
		chk("no reset while disabled", 16'(wdt_cnt), 16'h0000);
		wr(ADDR_CNT_LO, 8'h00);
		wr(ADDR_COUNTER_MODE_REG, 8'h44);
		t0(2);
		settle(3);
		chk("watchdog reset pulse", 16'(wdt_cnt), 16'h0001);
		// software keeps the compare value ahead of the counter
		for (int k = 5; k < 8; k++) begin
			wr(ADDR_VLO0 + 8'd4, 8'(k));
			t0(1);
		end
		settle(3);
		chk("watchdog held off", 16'(wdt_cnt), 16'h0001);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		sc_reset;
		sc_sources;
		sc_idle;
		sc_overflow;
		sc_compare;
		sc_capture;
		sc_pwm;
		sc_wdt;
		final_report;
	end
	// a hang ends the run as a failure
	initial begin
		repeat (20_000) @(posedge ref_clk);
		n_mismatch++;
		final_report;
	end
endmodule
